// >>> src/tbh_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TBH_DEFS_SVH
`define TBH_DEFS_SVH
`define TBH_A_STATUS 3'h0
`define TBH_A_DIAG 3'h1
`define TBH_A_PTRHI 3'h2
`define TBH_A_PTRLO 3'h3
`define TBH_A_DATA 3'h4
`define TBH_A_INDIRECT_REGISTER_SELECT 3'h5
`define TBH_A_CONFIG 3'h6
`define TBH_A_INDIRECT 3'h7
`define TBH_SUB_NEXTID 3'h3
`define TBH_SUB_SPEED 3'h2
`define TBH_SUB_CLOCK 3'h4
`define TBH_SUB_BUSCTL 3'h5
`define TBH_STATUS_RST 8'h91
`define TBH_DIAG_RST 8'h00
`define TBH_NEXTID_RST 8'h00
`define TBH_CONFIG_RST 8'h18
`define TBH_SPEED_RST 8'h00
`define TBH_CLOCK_RST 8'h00
`define TBH_BUSCTL_RST 8'h00
`define TBH_DIAG_NEWNEXT 2
`define TBH_DIAG_EXCESSIVE_REFUSAL_FLAG 6
`define TBH_DIAG_KEEP 8'h44
`define TBH_CMD_POR_CLEAR 8'h0E
`define TBH_PTRHI_DMA_REQUEST_ENABLE 3
`define TBH_BUSCTL_WIDE 7
`define TBH_CFG_RESET 7
`define TBH_CFG_TXJOIN 5
`define TBH_SPD_CKP_LSB 1
`define TBH_SPD_CKP_MAX 3'h6
`define TBH_CLK_FASTRD 7
`define TBH_CLK_MUL_LSB 4
`define TBH_CLK_ENH 3
`define TBH_CLK_NOIDLE 2
`define TBH_CLK_RCN_LSB 0
`define TBH_CLK_MHZ 200
`define TBH_RECON0_US 210000
`define TBH_RECON1_US 52500
`define TBH_RECON2_US 26250
`define TBH_RECON3_US 13125
`define TBH_RECON0_CYC (`TBH_RECON0_US * `TBH_CLK_MHZ)
`define TBH_RECON1_CYC (`TBH_RECON1_US * `TBH_CLK_MHZ)
`define TBH_RECON2_CYC (`TBH_RECON2_US * `TBH_CLK_MHZ)
`define TBH_RECON3_CYC (`TBH_RECON3_US * `TBH_CLK_MHZ)
`define TBH_AV_HOSTCTRL 4'h8
`define TBH_AV_HOSTSTAT 4'h9
`define TBH_HC_NODE255 0
`define TBH_HS_BADCMD 0
`define TBH_HS_BADORDER 1
`define TBH_HS_BADRECON 2
`define TBH_HS_DMAREQ 3
`endif

// >>> src/tbh_device_end.sv
// register bank of the token bus node controller
//
// Overview of operation
// - read-only next token holder id register
// - id updates set new-next flag; read clears
// - next_token_holder_id clears on any reset
// - status resets to 1xx1 0001
// - diag read clears all but two flags
// - refusal flag cleared by command or reset
// - diag resets to 0000 000x
// - host writes only defined command codes
// - pointer loads on low byte, high first
// - pointer high bit 3 gates dma request
// - wide access turns pointer bit 0 into swap
// - configuration resets 0x18, hardware reset only
// - select bits shared with configuration register
// - upper select bit; configuration write clears it
// - host writes zeros to select bits 7:3
// - speed setup: rate, arbitration, receive, driver
// - speed setup zero on hardware reset only
// - clock multiplier field and fast read bit
// - enhanced timing bit, else earlier timing
// - skip-idle bit lifts line idle wait
// - two-bit recon timeout at full rate
// - timeout scales with rate; shortest needs id 255
`timescale 1ns/1ps
`include "tbh_defs.svh"
module tbh_device_end #(
    parameter logic [31:0] RECON0_CYC = `TBH_RECON0_CYC,
    parameter logic [31:0] RECON1_CYC = `TBH_RECON1_CYC,
    parameter logic [31:0] RECON2_CYC = `TBH_RECON2_CYC,
    parameter logic [31:0] RECON3_CYC = `TBH_RECON3_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    tbh_if.device bus,
    input wire logic nextIdLoad,
    input wire logic [7:0] nextIdValue,
    input wire logic engineStatusLoad,
    input wire logic [7:0] engineStatus,
    input wire logic [7:0] diagSet,
    input wire logic dmaDone,
    input wire logic lineIdle,
    output logic cmdStrobe,
    output logic [7:0] cmdCode,
    output logic ramAddrLoad,
    output logic [10:0] ramAddr,
    output logic byteSwap,
    output logic softResetActive,
    output logic transmitJoinEnable,
    output logic [7:0] speedSetup,
    output logic [7:0] clockSetup,
    output logic wideAccessEnable,
    output logic initWriteAllowed,
    output logic [31:0] reconTimeoutCycles,
    output logic newNextIdFlag,
    output logic excessiveRefusalFlag
);
    logic [7:0] nextHolderId;
    logic [7:0] nodeStatus;
    logic [7:0] diagFlags;
    logic [7:0] next_diagFlags;
    logic [7:0] ptrUpper;
    logic [7:0] ptrLower;
    logic [7:2] modeCfg;
    logic [1:0] selLow;
    logic selHigh;
    logic [1:0] selSpare;
    logic [7:0] busCtl;
    logic [7:0] rdMux;
    logic [2:0] ckp;
    logic [31:0] reconBase;
    logic wrAt [8];
    logic rdAt [8];
    logic [2:0] subSel;

    assign subSel = {selHigh, selLow};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dec
            assign wrAt[gi] = bus.busWr && (bus.busAddr == 3'(gi));
            assign rdAt[gi] = bus.busRd && (bus.busAddr == 3'(gi));
        end
    endgenerate

    logic rdNextId;
    logic wrIndirect;
    assign rdNextId = rdAt[`TBH_A_INDIRECT] && subSel == `TBH_SUB_NEXTID;
    assign wrIndirect = wrAt[`TBH_A_INDIRECT];

    // soft reset follows the configuration reset bit, a registered level
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            softResetActive <= 1'b0;
        end else begin
            softResetActive <= modeCfg[`TBH_CFG_RESET];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nextHolderId <= `TBH_NEXTID_RST;
        end else if (softResetActive) begin
            nextHolderId <= `TBH_NEXTID_RST;
        end else if (nextIdLoad) begin
            nextHolderId <= nextIdValue;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nodeStatus <= `TBH_STATUS_RST;
        end else if (softResetActive) begin
            nodeStatus <= `TBH_STATUS_RST;
        end else if (engineStatusLoad) begin
            nodeStatus <= engineStatus;
        end
    end

    // an event in the clearing cycle wins, so none is lost
    always_comb begin
        next_diagFlags = diagFlags;
        if (rdAt[`TBH_A_DIAG]) begin
            next_diagFlags = next_diagFlags & `TBH_DIAG_KEEP;
        end
        if (rdNextId) begin
            next_diagFlags[`TBH_DIAG_NEWNEXT] = 1'b0;
        end
        if (wrAt[`TBH_A_DIAG] && bus.busWrData == `TBH_CMD_POR_CLEAR) begin
            next_diagFlags[`TBH_DIAG_EXCESSIVE_REFUSAL_FLAG] = 1'b0;
        end
        next_diagFlags = next_diagFlags | diagSet;
        if (nextIdLoad) begin
            next_diagFlags[`TBH_DIAG_NEWNEXT] = 1'b1;
        end
        next_diagFlags[0] = 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            diagFlags <= `TBH_DIAG_RST;
        end else if (softResetActive) begin
            diagFlags <= `TBH_DIAG_RST;
        end else begin
            diagFlags <= next_diagFlags;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmdStrobe <= 1'b0;
            cmdCode <= 8'h00;
        end else begin
            cmdStrobe <= wrAt[`TBH_A_DIAG];
            if (wrAt[`TBH_A_DIAG]) begin
                cmdCode <= bus.busWrData;
            end
        end
    end

    // pointer bytes have no defined reset; zero keeps simulation clean
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ptrUpper <= 8'h00;
            ptrLower <= 8'h00;
            ramAddr <= 11'h000;
            ramAddrLoad <= 1'b0;
            byteSwap <= 1'b0;
        end else begin
            ramAddrLoad <= wrAt[`TBH_A_PTRLO];
            if (wrAt[`TBH_A_PTRHI]) begin
                ptrUpper <= bus.busWrData;
            end
            if (wrAt[`TBH_A_PTRLO]) begin
                ptrLower <= bus.busWrData;
                ramAddr <= {ptrUpper[2:0], bus.busWrData};
                byteSwap <= 1'b0;
                if (wideAccessEnable) begin
                    ramAddr[0] <= 1'b0;
                    byteSwap <= bus.busWrData[0];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus.dmaRequestPin <= 1'b0;
        end else if (wrAt[`TBH_A_PTRLO]) begin
            bus.dmaRequestPin <= ptrUpper[`TBH_PTRHI_DMA_REQUEST_ENABLE];
        end else if (dmaDone) begin
            bus.dmaRequestPin <= 1'b0;
        end
    end

    // configuration survives a soft reset, otherwise the reset bit
    // could never be cleared again
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            modeCfg <= 6'(`TBH_CONFIG_RST >> 2);
            selLow <= 2'(`TBH_CONFIG_RST);
            selHigh <= 1'b0;
            selSpare <= 2'h0;
        end else if (wrAt[`TBH_A_CONFIG]) begin
            modeCfg <= bus.busWrData[7:2];
            selLow <= bus.busWrData[1:0];
            selHigh <= 1'b0;
        end else if (wrAt[`TBH_A_INDIRECT_REGISTER_SELECT]) begin
            selLow <= bus.busWrData[1:0];
            selHigh <= bus.busWrData[2];
            selSpare <= {bus.busWrData[7], bus.busWrData[3]};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            speedSetup <= `TBH_SPEED_RST;
            clockSetup <= `TBH_CLOCK_RST;
            busCtl <= `TBH_BUSCTL_RST;
        end else if (wrIndirect) begin
            case (subSel)
                `TBH_SUB_SPEED: speedSetup <= bus.busWrData;
                `TBH_SUB_CLOCK: clockSetup <= bus.busWrData;
                `TBH_SUB_BUSCTL: busCtl <= bus.busWrData;
                default: ;
            endcase
        end
    end

    // rate divider exponent; beyond 6 the slowest rate is held
    always_comb begin
        ckp = speedSetup[`TBH_SPD_CKP_LSB +: 3];
        if (ckp > `TBH_SPD_CKP_MAX) begin
            ckp = `TBH_SPD_CKP_MAX;
        end
        case (clockSetup[`TBH_CLK_RCN_LSB +: 2])
            2'h0: reconBase = RECON0_CYC;
            2'h1: reconBase = RECON1_CYC;
            2'h2: reconBase = RECON2_CYC;
            2'h3: reconBase = RECON3_CYC;
            default: reconBase = RECON0_CYC;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reconTimeoutCycles <= RECON0_CYC;
            initWriteAllowed <= 1'b0;
            wideAccessEnable <= 1'b0;
            transmitJoinEnable <= 1'b0;
            newNextIdFlag <= 1'b0;
            excessiveRefusalFlag <= 1'b0;
        end else begin
            reconTimeoutCycles <= reconBase << ckp;
            initWriteAllowed <= lineIdle
                || clockSetup[`TBH_CLK_NOIDLE];
            wideAccessEnable <= busCtl[`TBH_BUSCTL_WIDE];
            transmitJoinEnable <= modeCfg[`TBH_CFG_TXJOIN];
            newNextIdFlag <= diagFlags[`TBH_DIAG_NEWNEXT];
            excessiveRefusalFlag <= diagFlags[`TBH_DIAG_EXCESSIVE_REFUSAL_FLAG];
        end
    end

    always_comb begin
        case (bus.busAddr)
            `TBH_A_STATUS: rdMux = nodeStatus;
            `TBH_A_DIAG: rdMux = diagFlags;
            `TBH_A_PTRHI: rdMux = ptrUpper;
            `TBH_A_PTRLO: rdMux = ptrLower;
            `TBH_A_INDIRECT_REGISTER_SELECT: rdMux = {selSpare[1], 3'h0, selSpare[0],
                subSel};
            `TBH_A_CONFIG: rdMux = {modeCfg, selLow};
            `TBH_A_INDIRECT: begin
                case (subSel)
                    `TBH_SUB_NEXTID: rdMux = nextHolderId;
                    `TBH_SUB_SPEED: rdMux = speedSetup;
                    `TBH_SUB_CLOCK: rdMux = clockSetup;
                    `TBH_SUB_BUSCTL: rdMux = busCtl;
                    default: rdMux = 8'h00;
                endcase
            end
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus.busRdData <= 8'h00;
        end else if (bus.busRd) begin
            bus.busRdData <= rdMux;
        end
    end
endmodule : tbh_device_end

// >>> src/tbh_host_end.sv
// controller end: avalon-mm slave that drives the register bank bus
`timescale 1ns/1ps
`include "tbh_defs.svh"
module tbh_host_end (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    tbh_if.host bus
);
    tbh_pkg::tbh_host_state_e state;
    logic node255Present;
    logic [3:0] hostFlags;
    logic highPending;
    logic [1:0] shadowSelLow;
    logic shadowSelHigh;
    logic isDev;
    logic [7:0] wrByte;
    logic refuseCmd;
    logic refuseOrder;
    logic refuseRecon;
    logic refuse;
    logic [3:0] flagSet;

    assign isDev = (avsAddress[3] == 1'b0);
    assign wrByte = avsWriteData[7:0];
    assign refuseCmd = avsAddress[2:0] == `TBH_A_DIAG
        && !tbh_pkg::tbh_cmd_legal(wrByte);
    assign refuseOrder = avsAddress[2:0] == `TBH_A_PTRLO
        && !highPending;
    assign refuseRecon = avsAddress[2:0] == `TBH_A_INDIRECT
        && {shadowSelHigh, shadowSelLow} == `TBH_SUB_CLOCK
        && wrByte[`TBH_CLK_RCN_LSB +: 2] == 2'h3
        && !node255Present;
    assign refuse = refuseCmd || refuseOrder || refuseRecon;

    logic takeWr;
    assign takeWr = state == tbh_pkg::ST_IDLE && avsWrite
        && avsByteEnable[0];

    always_comb begin
        flagSet = 4'h0;
        if (takeWr && isDev) begin
            flagSet[`TBH_HS_BADCMD] = refuseCmd;
            flagSet[`TBH_HS_BADORDER] = refuseOrder;
            flagSet[`TBH_HS_BADRECON] = refuseRecon;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= tbh_pkg::ST_IDLE;
            avsWaitRequest <= 1'b1;
            avsReadData <= 32'h0000_0000;
            bus.busAddr <= 3'h0;
            bus.busWrData <= 8'h00;
            bus.busRd <= 1'b0;
            bus.busWr <= 1'b0;
        end else begin
            case (state)
                tbh_pkg::ST_IDLE: begin
                    if (avsRead || avsWrite) begin
                        avsReadData <= 32'h0000_0000;
                        if (isDev && (avsRead || (takeWr && !refuse))) begin
                            bus.busAddr <= avsAddress[2:0];
                            bus.busWrData <= wrByte;
                            if (avsAddress[2:0] == `TBH_A_INDIRECT_REGISTER_SELECT) begin
                                bus.busWrData[7:3] <= 5'h00;
                            end
                            bus.busRd <= avsRead;
                            bus.busWr <= avsWrite;
                            state <= tbh_pkg::ST_STROBE;
                        end else begin
                            if (avsRead && avsAddress == `TBH_AV_HOSTCTRL) begin
                                avsReadData <= {31'h0, node255Present};
                            end
                            if (avsRead && avsAddress == `TBH_AV_HOSTSTAT) begin
                                avsReadData <= {28'h0, bus.dmaRequestPin,
                                    hostFlags[2:0]};
                            end
                            avsWaitRequest <= 1'b0;
                            state <= tbh_pkg::ST_ACK;
                        end
                    end
                end
                tbh_pkg::ST_STROBE: begin
                    bus.busRd <= 1'b0;
                    bus.busWr <= 1'b0;
                    state <= tbh_pkg::ST_CAPTURE;
                end
                tbh_pkg::ST_CAPTURE: begin
                    avsReadData <= {24'h0, bus.busRdData};
                    avsWaitRequest <= 1'b0;
                    state <= tbh_pkg::ST_ACK;
                end
                tbh_pkg::ST_ACK: begin
                    avsWaitRequest <= 1'b1;
                    state <= tbh_pkg::ST_IDLE;
                end
                default: state <= tbh_pkg::ST_IDLE;
            endcase
        end
    end

    // shadows of the bank's select bits and pointer order, kept from
    // our own writes so refusals need no read-back of the bank
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            highPending <= 1'b0;
            shadowSelLow <= 2'(`TBH_CONFIG_RST);
            shadowSelHigh <= 1'b0;
        end else if (takeWr && isDev && !refuse) begin
            case (avsAddress[2:0])
                `TBH_A_PTRHI: highPending <= 1'b1;
                `TBH_A_PTRLO: highPending <= 1'b0;
                `TBH_A_CONFIG: begin
                    shadowSelLow <= wrByte[1:0];
                    shadowSelHigh <= 1'b0;
                end
                `TBH_A_INDIRECT_REGISTER_SELECT: begin
                    shadowSelLow <= wrByte[1:0];
                    shadowSelHigh <= wrByte[2];
                end
                default: ;
            endcase
        end
    end

    // sticky refusal flags: write one to clear, a new refusal wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hostFlags <= 4'h0;
            node255Present <= 1'b0;
        end else begin
            if (takeWr && avsAddress == `TBH_AV_HOSTCTRL) begin
                node255Present <= wrByte[`TBH_HC_NODE255];
            end
            if (takeWr && avsAddress == `TBH_AV_HOSTSTAT) begin
                hostFlags <= (hostFlags & ~wrByte[3:0]) | flagSet;
            end else begin
                hostFlags <= hostFlags | flagSet;
            end
        end
    end
endmodule : tbh_host_end

// >>> src/tbh_if.sv
// parallel register bus between controller and register bank
`timescale 1ns/1ps
interface tbh_if;
    logic [2:0] busAddr;
    logic [7:0] busWrData;
    logic busRd;
    logic busWr;
    logic [7:0] busRdData;
    logic dmaRequestPin;

    modport device (
        input busAddr,
        input busWrData,
        input busRd,
        input busWr,
        output busRdData,
        output dmaRequestPin
    );
    modport host (
        output busAddr,
        output busWrData,
        output busRd,
        output busWr,
        input busRdData,
        input dmaRequestPin
    );
endinterface : tbh_if

// >>> src/tbh_pkg.sv
// shared types of the register bank and its controller
package tbh_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_CAPTURE = 2'b10,
        ST_ACK = 2'b11
    } tbh_host_state_e;

    // defined command set: any code whose low three bits are not all zero
    function automatic logic tbh_cmd_legal(input logic [7:0] code);
        tbh_cmd_legal = (code[2:0] != 3'h0);
    endfunction : tbh_cmd_legal
endpackage : tbh_pkg

// >>> test/tbh_bus_assertions.sv
// bus checks between the controller end and the register bank end
`timescale 1ns/1ps
module tbh_bus_assertions (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [2:0] busAddr,
    input wire logic [7:0] busWrData,
    input wire logic busRd,
    input wire logic busWr,
    input wire logic [7:0] busRdData,
    input wire logic dmaRequestPin
);
    logic [7:0] cfg, spd, clkSet;
    logic selHi, dma_request_enable;
    logic [2:0] sel;
    wire logic ptrLoWr = busWr && busAddr == 3'h3;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    assign sel = {selHi, cfg[1:0]};
    // mirror of what the bus wrote; only a hardware reset restores it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {cfg, spd, clkSet} <= {8'h18, 8'h00, 8'h00};
            {selHi, dma_request_enable} <= 2'h0;
        end else if (busWr) begin
            case (busAddr)
                3'h2: dma_request_enable <= busWrData[3];
                3'h5: {selHi, cfg[1:0]} <= busWrData[2:0];
                3'h6: {selHi, cfg} <= {1'b0, busWrData};
                3'h7: begin
                    if (sel == 3'h2) spd <= busWrData;
                    if (sel == 3'h4) clkSet <= busWrData;
                end
                default: ;
            endcase
        end
    end
    AST_RD_PULSE: assert property (busRd |=> !busRd)
        else $error("read strobe longer than one cycle");
    AST_WR_PULSE: assert property (busWr |=> !busWr)
        else $error("write strobe longer than one cycle");
    AST_RD_WR_EXCL: assert property (!(busRd && busWr))
        else $error("read and write strobes together");
    AST_DMA_LOAD: assert property (ptrLoWr
        |=> dmaRequestPin == dma_request_enable)
        else $error("dma request does not follow pointer enable bit");
    AST_DMA_CAUSE: assert property ($rose(dmaRequestPin)
        |-> $past(ptrLoWr))
        else $error("dma request rose without a low pointer write");
    AST_SEL_READ: assert property (busRd && busAddr == 3'h5
        |=> busRdData == {5'h00, sel}) else $error("select readback wrong");
    AST_CFG_READ: assert property (busRd && busAddr == 3'h6
        |=> busRdData == cfg) else $error("config readback wrong");
    AST_SPD_READ: assert property (busRd && busAddr == 3'h7
        && sel == 3'h2 |=> busRdData == spd)
        else $error("speed setup readback wrong");
    AST_CLK_READ: assert property (busRd && busAddr == 3'h7
        && sel == 3'h4 |=> busRdData == clkSet)
        else $error("clock setup readback wrong");
    AST_RDDATA_HOLD: assert property (!$past(busRd) |-> $stable(busRdData))
        else $error("read data changed without a read");
    cover property (ptrLoWr && dma_request_enable);
    cover property (busRd && busAddr == 3'h7 && sel == 3'h3);
    cover property ($fell(dmaRequestPin));
endmodule : tbh_bus_assertions

// >>> test/token_bus_host_register_bank_tb.sv
// self-checking bench joining the controller end and the register bank
`timescale 1ns/1ps
module token_bus_host_register_bank_tb;
    localparam logic [31:0] RCN [4] = '{32'h64, 32'h19, 32'h0C, 32'h06};
    logic mclk, reset_n, avsRead, avsWrite, avsWaitRequest, nextIdLoad;
    logic [3:0] avsAddress, avsByteEnable;
    logic [31:0] avsWriteData, avsReadData, reconTimeoutCycles;
    logic engineStatusLoad, dmaDone, lineIdle, cmdStrobe, ramAddrLoad;
    logic [7:0] nextIdValue, engineStatus, diagSet, cmdCode, speedSetup;
    logic [7:0] clockSetup, rd;
    logic byteSwap, softResetActive, transmitJoinEnable, wideAccessEnable;
    logic initWriteAllowed, newNextIdFlag, excessiveRefusalFlag;
    logic [10:0] ramAddr;
    int error_cnt = 0;
    int n_compared = 0;
    tbh_if bus ();
    tbh_host_end i_tbh_host_end (.*);
    // short recon counts keep the run brief
    tbh_device_end #(.RECON0_CYC(RCN[0]), .RECON1_CYC(RCN[1]),
        .RECON2_CYC(RCN[2]), .RECON3_CYC(RCN[3])) i_tbh_device_end (.*);
    tbh_bus_assertions i_tbh_bus_assertions (.mclk(mclk), .reset_n(reset_n),
        .busAddr(bus.busAddr), .busWrData(bus.busWrData), .busRd(bus.busRd),
        .busWr(bus.busWr), .busRdData(bus.busRdData),
        .dmaRequestPin(bus.dmaRequestPin));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [3:0] a,
        input logic [7:0] d);
        int n = 0;
        avsAddress <= a;
        avsWriteData <= {24'h000000, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk);
        while (avsWaitRequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                $display("ERROR waitrequest expected 0 seen %b", avsWaitRequest);
                stop_test();
            end
            @(posedge mclk);
        end
        rd = avsReadData[7:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge mclk);
    endtask : acc
    task automatic rchk(input string what, input logic [3:0] a,
        input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(what, {24'h000000, exp}, {24'h000000, rd});
    endtask : rchk
    task automatic eng(input logic ln, input logic ls, input logic [7:0] v,
        input logic [7:0] dg);
        nextIdLoad <= ln;
        engineStatusLoad <= ls;
        nextIdValue <= v;
        diagSet <= dg;
        @(posedge mclk);
        {nextIdLoad, engineStatusLoad} <= 2'h0;
        diagSet <= 8'h00;
        repeat (2) @(posedge mclk);
    endtask : eng
    task automatic t_reset;
        rchk("status", 4'h0, 8'h91);
        rchk("diag", 4'h1, 8'h00);
        rchk("config", 4'h6, 8'h18);
        acc(1'b1, 4'h5, 8'h03);
        rchk("next_token_holder_id", 4'h7, 8'h00);
        acc(1'b1, 4'h5, 8'h02);
        rchk("speed setup", 4'h7, 8'h00);
    endtask : t_reset
    task automatic t_next_token_holder_id;
        acc(1'b1, 4'h5, 8'h03);
        eng(1'b1, 1'b0, 8'h2A, 8'h00);
        chk("new next flag", 32'h1, {31'h0, newNextIdFlag});
        rchk("diag", 4'h1, 8'h04);
        rchk("diag again", 4'h1, 8'h04);
        // a write to the id must be ignored
        acc(1'b1, 4'h7, 8'hFF);
        rchk("next_token_holder_id", 4'h7, 8'h2A);
        rchk("diag after id read", 4'h1, 8'h00);
    endtask : t_next_token_holder_id
    task automatic t_diag;
        eng(1'b0, 1'b0, 8'h00, 8'h42);
        rchk("diag", 4'h1, 8'h42);
        rchk("diag cleared", 4'h1, 8'h40);
        acc(1'b1, 4'h1, 8'h0E);
        chk("command", 32'h0E, {24'h0, cmdCode});
        rchk("diag after command", 4'h1, 8'h00);
    endtask : t_diag
    task automatic t_pointer;
        acc(1'b1, 4'h2, 8'h0D);
        acc(1'b1, 4'h3, 8'h35);
        chk("ram address", 32'h535, {21'h0, ramAddr});
        chk("dma request", 32'h1, {31'h0, bus.dmaRequestPin});
        dmaDone <= 1'b1;
        @(posedge mclk);
        dmaDone <= 1'b0;
        acc(1'b1, 4'h2, 8'h05);
        acc(1'b1, 4'h3, 8'h36);
        chk("dma idle", 32'h0, {31'h0, bus.dmaRequestPin});
        acc(1'b1, 4'h5, 8'h05);
        acc(1'b1, 4'h7, 8'h80);
        acc(1'b1, 4'h2, 8'h05);
        acc(1'b1, 4'h3, 8'h37);
        chk("byte swap", 32'h1, {31'h0, byteSwap});
    endtask : t_pointer
    task automatic t_select;
        acc(1'b1, 4'h5, 8'h06);
        rchk("select", 4'h5, 8'h06);
        acc(1'b1, 4'h6, 8'h39);
        rchk("select after config", 4'h5, 8'h01);
        rchk("config", 4'h6, 8'h39);
    endtask : t_select
    task automatic t_setup;
        acc(1'b1, 4'h5, 8'h02);
        acc(1'b1, 4'h7, 8'h4C);
        rchk("speed setup", 4'h7, 8'h4C);
        acc(1'b1, 4'h8, 8'h01);
        acc(1'b1, 4'h5, 8'h04);
        for (int r = 0; r < 4; r++) begin
            acc(1'b1, 4'h7, 8'h8C | 8'(r));
            repeat (2) @(posedge mclk);
            chk("clock setup", 32'h8C | r, {24'h0, clockSetup});
            chk("recon", RCN[r] << 6, reconTimeoutCycles);
        end
        chk("init allowed", 32'h1, {31'h0, initWriteAllowed});
        acc(1'b1, 4'h7, 8'h08);
        rchk("enhanced timing", 4'h7, 8'h08);
        chk("init held", 32'h0, {31'h0, initWriteAllowed});
        lineIdle <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("init idle", 32'h1, {31'h0, initWriteAllowed});
    endtask : t_setup
    task automatic t_refuse;
        acc(1'b1, 4'h1, 8'h08);
        acc(1'b1, 4'h3, 8'h10);
        acc(1'b1, 4'h8, 8'h00);
        acc(1'b1, 4'h7, 8'h03);
        rchk("host flags", 4'h9, 8'h07);
        chk("command kept", 32'h0E, {24'h0, cmdCode});
        rchk("clock kept", 4'h7, 8'h08);
    endtask : t_refuse
    task automatic t_soft;
        eng(1'b1, 1'b1, 8'h11, 8'h40);
        rchk("status loaded", 4'h0, 8'h00);
        acc(1'b1, 4'h6, 8'h98);
        rchk("status", 4'h0, 8'h91);
        rchk("diag", 4'h1, 8'h00);
        rchk("config kept", 4'h6, 8'h98);
        acc(1'b1, 4'h6, 8'h18);
        acc(1'b1, 4'h5, 8'h03);
        rchk("next_token_holder_id", 4'h7, 8'h00);
        acc(1'b1, 4'h5, 8'h02);
        rchk("speed kept", 4'h7, 8'h4C);
    endtask : t_soft
    initial begin
        reset_n = 1'b0;
        {avsRead, avsWrite, nextIdLoad, engineStatusLoad} = 4'h0;
        {dmaDone, lineIdle} = 2'h0;
        avsAddress = 4'h0;
        avsByteEnable = 4'hF;
        avsWriteData = 32'h00000000;
        {nextIdValue, engineStatus, diagSet} = 24'h000000;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_next_token_holder_id();
        t_diag();
        t_pointer();
        t_select();
        t_setup();
        t_refuse();
        t_soft();
        stop_test();
    end
endmodule : token_bus_host_register_bank_tb
